// ---- hw/lcd_bus_access_sequencer.sv ----
// lcd bus access sequencer: single initiator accesses to framed panel accesses
// assumes initiator holds a request stable until accepted; one clock domain
`timescale 1ns/100ps
// Overview of operation
// - read data goes back to the initiator only at the read cycle end event.
// - chip select of a read is released at the read cycle end event.
// - chip select is asserted for as long as a panel access is in progress.
// - every initiator access ends with chip select going inactive.
// - at least one clock separates two successive panel reads.
// - the halves of a split wide write go out back to back.
// - chip select stays asserted across all halves of a split write.
// - write chip select drops at the write cycle end event before a new command is taken.
// - two separate initiator writes are always divided by a chip select release.
module lcd_bus_access_sequencer (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // cycle-end event settings
  input  wire logic [lcd_seq_pkg::CNT_W-1:0] i_read_cycle_end_event,
  input  wire logic [lcd_seq_pkg::CNT_W-1:0] i_write_cycle_end_event,
  // initiator request
  input  wire logic                        i_req_valid,
  output logic                             o_req_ready,
  input  wire logic                        i_req_write,
  input  wire lcd_seq_pkg::acc_size_t      i_req_size,
  input  wire logic [lcd_seq_pkg::DATA_W-1:0] i_req_wdata,
  // initiator answer
  output logic                             o_rsp_valid,
  output logic [lcd_seq_pkg::DATA_W-1:0]   o_rsp_rdata,
  // panel bus
  output logic                             o_panel_cs_n,
  output logic                             o_panel_we_n,
  output logic                             o_panel_re_n,
  output logic [lcd_seq_pkg::PANEL_W-1:0]  o_panel_d,
  output logic                             o_panel_d_oe,
  input  wire logic [lcd_seq_pkg::PANEL_W-1:0] i_panel_d
);
  import lcd_seq_pkg::*;

  // ****************************************
  // state
  // ****************************************
  seq_state_t         state_q;
  logic               second_q;
  logic               split_q;
  logic [PANEL_W-1:0] hi_half_q;
  logic [DATA_W-1:0]  rdata_q;
  logic               rsp_q;
  logic [PANEL_W-1:0] pd_q;
  logic               we_q;
  logic               re_q;
  logic               oe_q;
  logic [PANEL_W-1:0] din_q1;
  logic [PANEL_W-1:0] din_q2;
  logic [PANEL_W-1:0] din_q3;

  panel_xfer_if xfer ();

  panel_xfer_timer u_timer (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .xfer  (xfer.timer)
  );

  function automatic logic is_split(input acc_size_t sz);
    return sz == SIZE_32;
  endfunction

  // ****************************************
  // request handshake and transfer starts
  // ****************************************
  logic accept;
  logic half_next;
  logic read_end;
  logic write_end;

  // a new command is taken only from idle, never in the gap cycle
  assign o_req_ready  = (state_q == ST_IDLE);
  assign accept       = i_req_valid && o_req_ready;
  // second half starts on the very cycle the first half ends
  assign half_next    = (state_q == ST_WRITE) && xfer.done && split_q && !second_q;
  assign read_end     = (state_q == ST_READ) && xfer.done;
  assign write_end    = (state_q == ST_WRITE) && xfer.done && !half_next;
  assign xfer.start   = accept || half_next;
  assign xfer.end_cnt = (state_q == ST_READ || (accept && !i_req_write)) ?
                        i_read_cycle_end_event : i_write_cycle_end_event;

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= i_req_write ? ST_WRITE : ST_READ;
          end
        end
        ST_READ: begin
          if (read_end) begin
            state_q <= ST_GAP;
          end
        end
        ST_WRITE: begin
          if (write_end) begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // split write tracking
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      split_q <= 1'b0;
    end else if (accept) begin
      split_q <= i_req_write && is_split(i_req_size);
    end
  end

  // marks that the high half is on the bus
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      second_q <= 1'b0;
    end else if (accept) begin
      second_q <= 1'b0;
    end else if (half_next) begin
      second_q <= 1'b1;
    end
  end

  // ****************************************
  // panel strobes
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (accept) begin
      we_q <= i_req_write;
      re_q <= !i_req_write;
      oe_q <= i_req_write;
    end else if (read_end || write_end) begin
      we_q <= 1'b0;
      re_q <= 1'b0;
      oe_q <= 1'b0;
    end
  end

  // ****************************************
  // panel write data
  // ****************************************
  // low half goes out first, high half is held for the second transfer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_q      <= '0;
      hi_half_q <= '0;
    end else if (accept) begin
      pd_q      <= i_req_wdata[PANEL_W-1:0];
      hi_half_q <= i_req_wdata[DATA_W-1:PANEL_W];
    end else if (half_next) begin
      pd_q <= hi_half_q;
    end
  end

  // ****************************************
  // panel pins
  // ****************************************
  // chip select held over both halves, dropped at the cycle-end event
  assign o_panel_cs_n = !(state_q == ST_READ || state_q == ST_WRITE);
  assign o_panel_we_n = !we_q;
  assign o_panel_re_n = !re_q;
  assign o_panel_d    = pd_q;
  assign o_panel_d_oe = oe_q;

  // ****************************************
  // read data path
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      din_q1 <= '0;
      din_q2 <= '0;
      din_q3 <= '0;
    end else begin
      din_q1 <= i_panel_d;
      din_q2 <= din_q1;
      din_q3 <= din_q2;
    end
  end

  logic din_stable;
  assign din_stable = (din_q2 == din_q3);

  // ****************************************
  // read answer
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rsp_q <= 1'b0;
    end else begin
      rsp_q <= read_end;
    end
  end

  // a word still settling in the synchroniser keeps the previous value
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= '0;
    end else if (read_end && din_stable) begin
      rdata_q <= {{(DATA_W-PANEL_W){1'b0}}, din_q3};
    end
  end

  assign o_rsp_valid = rsp_q;
  assign o_rsp_rdata = rdata_q;
endmodule // lcd_bus_access_sequencer

// ---- hw/lcd_seq_pkg.sv ----
// constants and types shared by the lcd bus access sequencer
// assumes a single 10 MHz clock domain
package lcd_seq_pkg;
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned PANEL_W        = 16;
  localparam int unsigned CNT_W          = 8;
  // cycle-end events are counts of panel clocks from the start of a transfer
  localparam logic [CNT_W-1:0] RD_END_DEF = 8'h04;
  localparam logic [CNT_W-1:0] WR_END_DEF = 8'h03;
  localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

  typedef enum logic [1:0] {
    SIZE_8  = 2'h0,
    SIZE_16 = 2'h1,
    SIZE_32 = 2'h2
  } acc_size_t;

  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_GAP
  } seq_state_t;
endpackage

// ---- hw/panel_xfer_if.sv ----
// carrier between sequencer and the transfer timer
// assumes both ends on i_clk
`timescale 1ns/100ps
interface panel_xfer_if;
  import lcd_seq_pkg::*;
  logic             start;
  logic [CNT_W-1:0] end_cnt;
  logic             done;
  modport ctrl  (output start, output end_cnt, input done);
  modport timer (input start, input end_cnt, output done);
endinterface

// ---- hw/panel_xfer_timer.sv ----
// one panel transfer timer: counts to the programmed cycle-end event
// assumes start is a single-cycle pulse, given while idle or in the done cycle of the running transfer
`timescale 1ns/100ps
module panel_xfer_timer (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // control side
  panel_xfer_if.timer     xfer
);
  import lcd_seq_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic             busy_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      cnt_q  <= CNT_ZERO;
    end else if (xfer.start) begin
      busy_q <= 1'b1;
      cnt_q  <= CNT_ONE;
    end else if (xfer.done) begin
      busy_q <= 1'b0;
      cnt_q  <= CNT_ZERO;
    end else if (busy_q) begin
      cnt_q <= cnt_q + CNT_ONE;
    end
  end

  // done marks the cycle-end event of the running transfer
  assign xfer.done = busy_q && (cnt_q >= xfer.end_cnt);
endmodule // panel_xfer_timer

// ---- test/lcd_panel_model.sv ----
// panel model: each read start shows a fresh word
// assumes active-low select and read strobe
`timescale 1ns/100ps
module lcd_panel_model (
  input wire logic        i_panel_cs_n,
  input wire logic        i_panel_re_n,
  output logic     [15:0] o_panel_d
);
  int          idx = 0;
  logic [15:0] val;
  always @(negedge i_panel_re_n) idx++;
  assign val = 16'(idx * 32'h3A5F) ^ 16'hC3C3;
  // outside a read the bus shows the inverse, never the stale word
  assign o_panel_d = (!i_panel_cs_n && !i_panel_re_n) ? val : ~val;
endmodule // lcd_panel_model

// ---- test/lcd_seq_checker.sv ----
// port checker for the lcd bus access sequencer
// assumes a bind by name from the bench top file
`timescale 1ns/100ps
module lcd_seq_checker
  import lcd_seq_pkg::*;
(
  input wire logic             i_clk,
  input wire logic             i_rst,
  input wire logic [CNT_W-1:0] i_read_cycle_end_event,
  input wire logic [CNT_W-1:0] i_write_cycle_end_event,
  input wire logic             i_req_valid,
  input wire logic             o_req_ready,
  input wire logic             i_req_write,
  input wire acc_size_t        i_req_size,
  input wire logic [31:0]      i_req_wdata,
  input wire logic             o_rsp_valid,
  input wire logic             o_panel_cs_n,
  input wire logic             o_panel_we_n,
  input wire logic             o_panel_re_n,
  input wire logic [15:0]      o_panel_d,
  input wire logic             o_panel_d_oe
);
  logic [CNT_W:0] n_q;
  logic           rd_q;
  logic           w32_q;
  logic [31:0]    wd_q;
  logic [CNT_W:0] rl;
  logic [CNT_W:0] wl;
  assign rl = {1'b0, i_read_cycle_end_event};
  assign wl = {1'b0, i_write_cycle_end_event};
  // cycles of the current chip select low stretch
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) n_q <= '0;
    else n_q <= o_panel_cs_n ? '0 : n_q + 1'b1;
  always_ff @(posedge i_clk)
    if (i_req_valid && o_req_ready) {rd_q, w32_q, wd_q} <= {!i_req_write,
      i_req_size == SIZE_32, i_req_wdata};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_rsp_at_end: assert property (
    o_rsp_valid |-> $rose(o_panel_cs_n) && rd_q) else $error("read answer before end");
  a_rd_cs_len: assert property (
    $rose(o_panel_cs_n) && rd_q |-> o_rsp_valid && n_q == rl) else $error("read cs length");
  a_cs_frames: assert property (
    i_req_valid && o_req_ready |=> !o_panel_cs_n && (rd_q ? !o_panel_re_n : !o_panel_we_n))
    else $error("access not framed");
  a_cs_release: assert property (
    !o_panel_cs_n |-> n_q < (rd_q ? rl : wl << 1)) else $error("cs held too long");
  a_gap_cycle: assert property (
    $rose(o_panel_cs_n) |-> !o_req_ready ##1 o_panel_cs_n && o_req_ready)
    else $error("no gap between accesses");
  a_split_data: assert property (
    !o_panel_cs_n && !rd_q |-> !o_panel_we_n && o_panel_d_oe &&
    o_panel_d == (n_q < wl ? wd_q[15:0] : wd_q[31:16])) else $error("split data");
  a_split_cs: assert property (
    $rose(o_panel_cs_n) && !rd_q |-> n_q == (w32_q ? wl << 1 : wl)) else $error("write cs");
  a_wr_release: assert property (
    $rose(o_panel_cs_n) && !rd_q |-> o_panel_we_n && !o_panel_d_oe)
    else $error("write strobe after release");
endmodule // lcd_seq_checker

// ---- test/tb_lcd_bus_access_sequencer.sv ----
// bench: random back-to-back reads and split writes
// assumes design package, checker and panel model compiled first
`timescale 1ns/100ps
module tb_lcd_bus_access_sequencer;
  import lcd_seq_pkg::*;
  logic i_clk, i_rst, i_req_valid, o_req_ready, i_req_write, o_rsp_valid;
  logic o_panel_cs_n, o_panel_we_n, o_panel_re_n, o_panel_d_oe;
  logic [CNT_W-1:0] i_read_cycle_end_event, i_write_cycle_end_event;
  acc_size_t i_req_size;
  logic [31:0] i_req_wdata, o_rsp_rdata;
  logic [15:0] o_panel_d, i_panel_d;
  logic [15:0] exp_q[$];
  int err_count, cmp_count, seed, n, nrd;
  lcd_bus_access_sequencer i_lcd_bus_access_sequencer (
    .i_clk                   (i_clk),
    .i_rst                   (i_rst),
    .i_read_cycle_end_event  (i_read_cycle_end_event),
    .i_write_cycle_end_event (i_write_cycle_end_event),
    .i_req_valid             (i_req_valid),
    .o_req_ready             (o_req_ready),
    .i_req_write             (i_req_write),
    .i_req_size              (i_req_size),
    .i_req_wdata             (i_req_wdata),
    .o_rsp_valid             (o_rsp_valid),
    .o_rsp_rdata             (o_rsp_rdata),
    .o_panel_cs_n            (o_panel_cs_n),
    .o_panel_we_n            (o_panel_we_n),
    .o_panel_re_n            (o_panel_re_n),
    .o_panel_d               (o_panel_d),
    .o_panel_d_oe            (o_panel_d_oe),
    .i_panel_d               (i_panel_d)
  );
  lcd_panel_model i_lcd_panel_model (.i_panel_cs_n(o_panel_cs_n),
    .i_panel_re_n(o_panel_re_n), .o_panel_d(i_panel_d));
  function automatic logic [15:0] pat(input int k);
    return 16'(k * 32'h3A5F) ^ 16'hC3C3;
  endfunction
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // a busy limit that runs out counts as a mismatch
  task automatic wait_ready();
    for (n = 0; n < 300 && !o_req_ready; n++) @(negedge i_clk);
    check("ready in time", 32'h1, {31'h0, o_req_ready});
  endtask
  // valid stays up across busy cycles to press for back-to-back issue
  task automatic acc(input logic w);
    i_req_valid = 1;
    i_req_write = w;
    i_req_size = w ? acc_size_t'(2'($random(seed)) % 2'h3) : SIZE_16;
    i_req_wdata = $random(seed);
    wait_ready();
    if (!w) nrd++;
    if (!w) exp_q.push_back(pat(nrd));
    @(posedge i_clk);
    #1;
  endtask
  always @(negedge i_clk)
    if (!i_rst && o_rsp_valid) begin
      check("read queued", 32'h1, {31'h0, exp_q.size() != 0});
      if (exp_q.size() != 0)
        check("read data", {16'h0000, exp_q.pop_front()}, o_rsp_rdata);
    end
  initial begin
    i_clk = 0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #500000;
    err_count++;
    print_verdict();
  end
  initial begin
    seed = 73653;
    nrd = 0;
    i_rst = 1;
    i_req_valid = 0;
    i_req_write = 0;
    i_req_size = SIZE_16;
    i_req_wdata = 32'h0;
    i_read_cycle_end_event = 8'h05;
    i_write_cycle_end_event = 8'h01;
    repeat (8) @(posedge i_clk);
    #1 i_rst = 0;
    for (int t = 0; t < 6; t++) begin
      if (t > 0) begin
        i_read_cycle_end_event = 8'h05 + 8'($random(seed) & 3);
        i_write_cycle_end_event = 8'h01 + 8'($random(seed) & 3);
      end
      for (int a = 0; a < 8; a++) acc(1'($random(seed)));
      i_req_valid = 0;
      wait_ready();
      @(posedge i_clk);
      #1 $display("test %0d done", t);
    end
    check("pending reads", 32'h0, exp_q.size());
    print_verdict();
  end
endmodule // tb_lcd_bus_access_sequencer
bind lcd_bus_access_sequencer lcd_seq_checker i_lcd_seq_checker (
  .i_clk                   (i_clk),
  .i_rst                   (i_rst),
  .i_read_cycle_end_event  (i_read_cycle_end_event),
  .i_write_cycle_end_event (i_write_cycle_end_event),
  .i_req_valid             (i_req_valid),
  .o_req_ready             (o_req_ready),
  .i_req_write             (i_req_write),
  .i_req_size              (i_req_size),
  .i_req_wdata             (i_req_wdata),
  .o_rsp_valid             (o_rsp_valid),
  .o_panel_cs_n            (o_panel_cs_n),
  .o_panel_we_n            (o_panel_we_n),
  .o_panel_re_n            (o_panel_re_n),
  .o_panel_d               (o_panel_d),
  .o_panel_d_oe            (o_panel_d_oe)
);
